// ==== omc_params.svh ====
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH

// Register byte offsets
`define OMC_OFS_OPTS 8'h38
`define OMC_OFS_MPRI 8'h3C

// Reset values and bus answer
`define OMC_PSEL_RST 5'h06
`define OMC_RESP_OKAY 1'b0

// Address windows
`define OMC_BROM_LO 16'hBE00
`define OMC_BROM_HI 16'hBFFF
`define OMC_VEC_LO 16'hBFC0
`define OMC_VEC_HI 16'hBFFF

// Boot download
`define OMC_BOOT_ENTRY 16'h0080
`define OMC_BOOT_LAST 16'h037F
`define OMC_BOOT_MAX 10'h300
`define OMC_IDLE_CHARS 3'h4

// Strobe high time: a quarter of the bus cycle, rounded down
`define OMC_CLK_NS 8
`define OMC_ECLK_NS 64
`define OMC_STRB_HI_NS (`OMC_ECLK_NS / 4)
`define OMC_STRB_HI_RAW (`OMC_STRB_HI_NS / `OMC_CLK_NS)
`define OMC_STRB_HI_CYC ((`OMC_STRB_HI_RAW < 1) ? 1 : `OMC_STRB_HI_RAW)

// Auxiliary clock: crystal rising edges per half period
`define OMC_XDIV_H4 3'h2
`define OMC_XDIV_H6 3'h3
`define OMC_XDIV_H8 3'h4

`endif

// ==== omc_pkg.sv ====
package omc_pkg;

   typedef enum logic [1:0] {
      omc_md_single = 2'h0,
      omc_md_expand = 2'h1,
      omc_md_boot = 2'h2,
      omc_md_test = 2'h3
   } omc_mode_e;

   typedef enum logic [1:0] {
      omc_bl_idle = 2'h0,
      omc_bl_load = 2'h1,
      omc_bl_done = 2'h2
   } omc_bl_e;

   typedef struct packed {
      logic boot_rom_enable;
      logic special_mode_flag;
      logic mode_select_a_flag;
      logic [4:0] psel;
   } omc_mpri_s;

   typedef struct packed {
      logic strobe_drive_high;
      logic portc_open_drain;
      logic rsvd;
      logic read_visibility_or_eclk_gate;
      logic spi_low_bit_first;
      logic spi_rate_bit_two;
      logic [1:0] aux_clock_divider;
   } omc_opts_s;

endpackage

// ==== omc_clk_div.sv ====
`timescale 1ns/1ps
`include "omc_params.svh"
module omc_clk_div
   import omc_pkg::*;
#(
   parameter int W = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Crystal and divider select
   input wire logic crystal_input,
   input wire logic [1:0] div_sel,
   // Divided clock
   output logic aux_clock_output
);

   logic xtal_q_r;
   logic [W-1:0] cnt_r;
   logic [W-1:0] half;
   logic rise;

   assign rise = crystal_input && !xtal_q_r;

   always_comb begin
      unique case (div_sel)
         2'h1: half = W'(`OMC_XDIV_H4);
         2'h2: half = W'(`OMC_XDIV_H6);
         2'h3: half = W'(`OMC_XDIV_H8);
         2'h0: half = W'(1);
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         xtal_q_r <= 1'b0;
      end else begin
         xtal_q_r <= crystal_input;
      end
   end

   // Divide by one passes the crystal through, one cycle late
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         aux_clock_output <= 1'b0;
      end else if (div_sel == 2'h0) begin
         cnt_r <= '0;
         aux_clock_output <= crystal_input;
      end else if (rise) begin
         if (cnt_r >= half - W'(1)) begin
            cnt_r <= '0;
            aux_clock_output <= !aux_clock_output;
         end else begin
            cnt_r <= cnt_r + W'(1);
         end
      end
   end

endmodule // omc_clk_div

// ==== omc_top.sv ====
`timescale 1ns/1ps
`include "omc_params.svh"
// Functional notes
// - Mode pins are latched into the mode flags as reset is released.
// - B1A0 single-chip, B1A1 expanded, B0A0 bootstrap, B0A1 special test.
// - Boot ROM bit resets set only in bootstrap; priority select resets 00110.
// - Boot ROM bit works only with special flag; writable only in special modes.
// - Boot ROM bit set maps the boot ROM at BE00..BFFF; clear removes it.
// - Mode flags always readable; freely writable in special modes.
// - In normal modes only the first mode-A write after reset counts.
// - Special flag, once cleared, cannot be set again until reset.
// - Boot ROM is mapped only while the boot ROM bit and the special flag are both set.
// - Bootstrap download ends at 037F or four idle characters; jump to 0080.
// - Special test removes ROM and fetches vectors externally at BFC0..BFFF.
// - Expanded mode drives address on B and F, data on C, and R/W.
// - Extended address lines 18..13 leave on port G only in expanded mode.
// - Single-chip mode has no external address or data bus.
// - Options bit 5 reads zero; other option bits except visibility reset zero.
// - Strobe only pulls low unless drive-high bit set; no effect without bus.
// - Visibility bit writable once in normal modes, anytime in special modes.
// - Visibility bit resets to one in special test, zero otherwise.
// - With bus modes, visibility bit puts internal read data on port C.
// - Without bus, visibility bit zero runs E out, one holds E low.
// - Divider codes 0..3 give crystal divided by 1, 4, 6, 8.
// - Software may change the mode by writing the mode flags.
module omc_top
   import omc_pkg::*;
#(
   parameter int STRB_HI_CYC = `OMC_STRB_HI_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Mode pins and clocks
   input wire logic mode_pin_a,
   input wire logic mode_pin_b,
   input wire logic crystal_input,
   input wire logic e_clock,
   // CPU side
   input wire logic [15:0] cpu_addr,
   input wire logic [5:0] cpu_xaddr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic cpu_vec,
   input wire logic cpu_int_hit,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_int_rdata,
   input wire logic cpu_first_fetch,
   // Boot download monitor
   input wire logic ram_wr_pls,
   input wire logic [15:0] ram_wr_addr,
   input wire logic char_tick,
   // Mode and option state
   output logic boot_rom_enable,
   output logic special_mode_flag,
   output logic mode_select_a_flag,
   output logic [4:0] psel,
   output logic portc_open_drain,
   output logic spi_low_bit_first,
   output logic spi_rate_bit_two,
   // Memory map
   output logic brom_sel,
   output logic rom_off,
   output logic vec_ext,
   output logic boot_done,
   output logic [15:0] boot_jump,
   // Expansion bus pins
   output logic ext_bus_en,
   output logic [7:0] portb_out,
   output logic [7:0] portf_out,
   output logic [7:0] portc_out,
   output logic portc_oe_b,
   output logic rw_out,
   output logic [5:0] expansion_address,
   output logic expansion_address_en,
   // Strobe, E and auxiliary clock
   output logic first_instruction_strobe,
   output logic first_instruction_strobe_oe_b,
   output logic eclk_out,
   output logic aux_clock_output
);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   logic strap_done_r;
   omc_mpri_s mpri_r;
   omc_opts_s opts_r;
   logic mda_once_r;
   logic rvis_once_r;
   omc_mode_e mode;
   logic ap_take;
   logic [7:0] ap_addr_r;
   logic wr_pend_r;
   logic rd_pend_r;
   logic mp_wr;
   logic op_wr;
   logic [7:0] rd_mux;
   omc_mpri_s mp_wd;
   omc_opts_s op_wd;

   assign mode = omc_mode_e'({mpri_r.special_mode_flag, mpri_r.mode_select_a_flag});

   // Bus slave: writes take no wait, reads take one so that data come from a flop
   assign ap_take = hsel && htrans[1] && hready;
   assign mp_wr = wr_pend_r && (ap_addr_r == `OMC_OFS_MPRI);
   assign op_wr = wr_pend_r && (ap_addr_r == `OMC_OFS_OPTS);
   assign mp_wd = omc_mpri_s'(hwdata[7:0]);
   assign op_wd = omc_opts_s'(hwdata[7:0]);

   always_comb begin
      rd_mux = 8'h00;
      if (ap_addr_r == `OMC_OFS_MPRI) begin
         rd_mux = mpri_r;
      end else if (ap_addr_r == `OMC_OFS_OPTS) begin
         rd_mux = {opts_r[7:6], 1'b0, opts_r[4:0]};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ap_addr_r <= 8'h00;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= `OMC_RESP_OKAY;
      end else begin
         wr_pend_r <= ap_take && hwrite;
         rd_pend_r <= ap_take && !hwrite;
         hreadyout <= !(ap_take && !hwrite);
         hresp <= `OMC_RESP_OKAY;
         if (ap_take) begin
            ap_addr_r <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend_r) begin
         hrdata <= {24'h00_0000, rd_mux};
      end
   end

   // Pins are caught at the first edge after release, never under reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         strap_done_r <= 1'b0;
      end else begin
         strap_done_r <= 1'b1;
      end
   end

   // Mode and priority register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mpri_r <= '0;
      end else if (!strap_done_r) begin
         mpri_r.special_mode_flag <= !mode_pin_b;
         mpri_r.mode_select_a_flag <= mode_pin_a;
         mpri_r.boot_rom_enable <= !mode_pin_b && !mode_pin_a;
         mpri_r.psel <= `OMC_PSEL_RST;
      end else if (mp_wr) begin
         mpri_r.psel <= mp_wd.psel;
         if (mpri_r.special_mode_flag) begin
            mpri_r.boot_rom_enable <= mp_wd.boot_rom_enable;
            mpri_r.special_mode_flag <= mp_wd.special_mode_flag;
            mpri_r.mode_select_a_flag <= mp_wd.mode_select_a_flag;
         end else if (!mda_once_r) begin
            mpri_r.mode_select_a_flag <= mp_wd.mode_select_a_flag;
         end
      end
   end

   // Only normal-mode writes use up the single allowed write
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mda_once_r <= 1'b0;
      end else if (mp_wr && !mpri_r.special_mode_flag) begin
         mda_once_r <= 1'b1;
      end
   end

   // Options register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         opts_r <= '0;
      end else if (!strap_done_r) begin
         opts_r.read_visibility_or_eclk_gate <= !mode_pin_b && mode_pin_a;
      end else if (op_wr) begin
         opts_r.strobe_drive_high <= op_wd.strobe_drive_high;
         opts_r.portc_open_drain <= op_wd.portc_open_drain;
         opts_r.spi_low_bit_first <= op_wd.spi_low_bit_first;
         opts_r.spi_rate_bit_two <= op_wd.spi_rate_bit_two;
         opts_r.aux_clock_divider <= op_wd.aux_clock_divider;
         if (mpri_r.special_mode_flag || !rvis_once_r) begin
            opts_r.read_visibility_or_eclk_gate <= op_wd.read_visibility_or_eclk_gate;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rvis_once_r <= 1'b0;
      end else if (op_wr && !mpri_r.special_mode_flag) begin
         rvis_once_r <= 1'b1;
      end
   end

   assign boot_rom_enable = mpri_r.boot_rom_enable;
   assign special_mode_flag = mpri_r.special_mode_flag;
   assign mode_select_a_flag = mpri_r.mode_select_a_flag;
   assign psel = mpri_r.psel;
   assign portc_open_drain = opts_r.portc_open_drain;
   assign spi_low_bit_first = opts_r.spi_low_bit_first;
   assign spi_rate_bit_two = opts_r.spi_rate_bit_two;

   // Memory map decode, one cycle behind the CPU address
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         brom_sel <= 1'b0;
         rom_off <= 1'b0;
         vec_ext <= 1'b0;
      end else begin
         brom_sel <= mpri_r.boot_rom_enable && mpri_r.special_mode_flag && cpu_rd
            && (cpu_addr >= `OMC_BROM_LO) && (cpu_addr <= `OMC_BROM_HI);
         rom_off <= (mode == omc_md_test);
         vec_ext <= (mode == omc_md_test) && cpu_vec
            && (cpu_addr >= `OMC_VEC_LO) && (cpu_addr <= `OMC_VEC_HI);
      end
   end

   // Expansion bus; special test keeps the bus so vectors can be fetched
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ext_bus_en <= 1'b0;
         portb_out <= 8'h00;
         portf_out <= 8'h00;
         rw_out <= 1'b1;
         expansion_address <= 6'h00;
         expansion_address_en <= 1'b0;
      end else begin
         ext_bus_en <= mpri_r.mode_select_a_flag;
         portb_out <= mpri_r.mode_select_a_flag ? cpu_addr[15:8] : 8'h00;
         portf_out <= mpri_r.mode_select_a_flag ? cpu_addr[7:0] : 8'h00;
         rw_out <= mpri_r.mode_select_a_flag ? !cpu_wr : 1'b1;
         expansion_address_en <= (mode == omc_md_expand);
         expansion_address <= (mode == omc_md_expand) ? cpu_xaddr : 6'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         portc_out <= 8'h00;
         portc_oe_b <= 1'b1;
      end else if (mpri_r.mode_select_a_flag && cpu_wr && !cpu_int_hit) begin
         portc_out <= cpu_wdata;
         portc_oe_b <= 1'b0;
      end else if (mpri_r.mode_select_a_flag && opts_r.read_visibility_or_eclk_gate
                   && cpu_rd && cpu_int_hit) begin
         portc_out <= cpu_int_rdata;
         portc_oe_b <= 1'b0;
      end else begin
         portc_out <= 8'h00;
         portc_oe_b <= 1'b1;
      end
   end

   // E clock runs regardless of the bit whenever a bus exists
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         eclk_out <= 1'b0;
      end else begin
         eclk_out <= (!mpri_r.mode_select_a_flag && opts_r.read_visibility_or_eclk_gate)
            ? 1'b0 : e_clock;
      end
   end

   // Strobe pin: pulls low while active, optional short high drive afterwards
   logic lir_q_r;
   logic [3:0] hi_cnt_r;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lir_q_r <= 1'b0;
         hi_cnt_r <= 4'h0;
         first_instruction_strobe <= 1'b0;
         first_instruction_strobe_oe_b <= 1'b1;
      end else begin
         lir_q_r <= cpu_first_fetch;
         if (cpu_first_fetch) begin
            hi_cnt_r <= 4'h0;
            first_instruction_strobe <= 1'b0;
            first_instruction_strobe_oe_b <= 1'b0;
         end else if (lir_q_r && opts_r.strobe_drive_high
                      && mpri_r.mode_select_a_flag) begin
            hi_cnt_r <= 4'(STRB_HI_CYC);
            first_instruction_strobe <= 1'b1;
            first_instruction_strobe_oe_b <= 1'b0;
         end else if (hi_cnt_r > 4'h1) begin
            hi_cnt_r <= hi_cnt_r - 4'h1;
         end else begin
            hi_cnt_r <= 4'h0;
            first_instruction_strobe <= 1'b0;
            first_instruction_strobe_oe_b <= 1'b1;
         end
      end
   end

   // Download monitor; the loader itself runs as firmware from the boot ROM
   omc_bl_e bl_st_r;
   logic [9:0] bl_bytes_r;
   logic [2:0] bl_idle_r;
   logic bl_last;

   assign bl_last = ram_wr_pls && (ram_wr_addr == `OMC_BOOT_LAST);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bl_st_r <= omc_bl_idle;
         bl_bytes_r <= 10'h000;
         bl_idle_r <= 3'h0;
         boot_done <= 1'b0;
         boot_jump <= 16'h0000;
      end else begin
         unique case (bl_st_r)
            omc_bl_idle: begin
               if (mode == omc_md_boot && ram_wr_pls) begin
                  bl_bytes_r <= 10'h001;
                  bl_idle_r <= 3'h0;
                  bl_st_r <= bl_last ? omc_bl_done : omc_bl_load;
                  boot_done <= bl_last;
                  boot_jump <= bl_last ? `OMC_BOOT_ENTRY : 16'h0000;
               end
            end
            omc_bl_load: begin
               if (ram_wr_pls) begin
                  bl_bytes_r <= bl_bytes_r + 10'h001;
                  bl_idle_r <= 3'h0;
                  if (bl_last || (bl_bytes_r + 10'h001 == `OMC_BOOT_MAX)) begin
                     bl_st_r <= omc_bl_done;
                     boot_done <= 1'b1;
                     boot_jump <= `OMC_BOOT_ENTRY;
                  end
               end else if (char_tick) begin
                  bl_idle_r <= bl_idle_r + 3'h1;
                  if (bl_idle_r + 3'h1 == `OMC_IDLE_CHARS) begin
                     bl_st_r <= omc_bl_done;
                     boot_done <= 1'b1;
                     boot_jump <= `OMC_BOOT_ENTRY;
                  end
               end
            end
            omc_bl_done: begin
               boot_done <= 1'b1;
            end
            default: begin
               bl_st_r <= omc_bl_idle;
            end
         endcase
      end
   end

   omc_clk_div #(
      .W(3)
   ) u_div (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .crystal_input(crystal_input),
      .div_sel(opts_r.aux_clock_divider),
      .aux_clock_output(aux_clock_output)
   );

   sequence s_norm_mp_wr;
      strap_done_r && mp_wr && !mpri_r.special_mode_flag;
   endsequence

   sequence s_bl_last;
      mode == omc_md_boot && bl_last && bl_st_r != omc_bl_done;
   endsequence

   sequence s_bl_idle_out;
      bl_st_r == omc_bl_load && !ram_wr_pls && char_tick && bl_idle_r == 3'h3;
   endsequence

   strap_load_a: assert property (
      rst_b && !strap_done_r |=> mpri_r.special_mode_flag == !$past(mode_pin_b)
         && mpri_r.mode_select_a_flag == $past(mode_pin_a))
      else $error("Mode flags not latched from mode pins");

   boot_reset_a: assert property (
      rst_b && !strap_done_r |=> mpri_r.psel == `OMC_PSEL_RST
         && mpri_r.boot_rom_enable == (!$past(mode_pin_b) && !$past(mode_pin_a))
         && opts_r.read_visibility_or_eclk_gate == (!$past(mode_pin_b) && $past(mode_pin_a)))
      else $error("Wrong mode dependent reset values");

   boot_guard_a: assert property (
      s_norm_mp_wr |=> $stable(mpri_r.boot_rom_enable))
      else $error("Boot ROM bit changed in normal mode");

   brom_map_a: assert property (
      brom_sel |-> $past(mpri_r.boot_rom_enable && mpri_r.special_mode_flag
         && cpu_addr >= `OMC_BROM_LO))
      else $error("Boot ROM selected while not mapped");

   mda_once_a: assert property (
      s_norm_mp_wr ##0 mda_once_r |=> $stable(mpri_r.mode_select_a_flag))
      else $error("Second mode A write accepted in normal mode");

   special_mode_flag_noset_a: assert property (
      strap_done_r && !mpri_r.special_mode_flag |=> !mpri_r.special_mode_flag)
      else $error("Special flag set again after clear");

   opts_bit5_a: assert property (
      rd_pend_r && ap_addr_r == `OMC_OFS_OPTS |=> !hrdata[5] && hreadyout)
      else $error("Options bit 5 read as one");

   rvis_once_a: assert property (
      strap_done_r && op_wr && !mpri_r.special_mode_flag && rvis_once_r
         |=> $stable(opts_r.read_visibility_or_eclk_gate))
      else $error("Visibility bit rewritten in normal mode");

   eclk_gate_a: assert property (
      !mpri_r.mode_select_a_flag && opts_r.read_visibility_or_eclk_gate |=> !eclk_out)
      else $error("E clock not held low");

   strb_nodrive_a: assert property (
      !mpri_r.mode_select_a_flag [*2] |=> !(first_instruction_strobe
         && !first_instruction_strobe_oe_b))
      else $error("Strobe driven high without expansion bus");

   xa_mode_a: assert property (
      expansion_address_en || !portc_oe_b |-> $past(mpri_r.mode_select_a_flag))
      else $error("Expansion pins active without a bus mode");

   boot_last_a: assert property (
      s_bl_last |=> boot_done && boot_jump == `OMC_BOOT_ENTRY)
      else $error("Download not ended at last address");

   boot_idle_a: assert property (
      s_bl_idle_out |=> boot_done ##1 boot_done)
      else $error("Download not ended after idle characters");

endmodule // omc_top

// ==== omc_ext_mem.sv ====
`timescale 1ns/1ps
module omc_ext_mem (
   // Clock
   input wire logic clk_sys,
   // Expansion bus pins
   input wire logic ext_bus_en,
   input wire logic [7:0] portb_out,
   input wire logic [7:0] portf_out,
   input wire logic [7:0] portc_out,
   input wire logic portc_oe_b,
   input wire logic rw_out,
   // Last write seen on the bus
   output logic [15:0] last_addr,
   output logic [7:0] last_data
);
   // Latch only while a bus exists and data is driven, as a real memory strobe would
   always_ff @(posedge clk_sys) begin
      if (ext_bus_en && !rw_out && !portc_oe_b) begin
         last_addr <= {portb_out, portf_out};
         last_data <= portc_out;
      end
   end
endmodule // omc_ext_mem

// ==== operating_mode_control_tb.sv ====
`timescale 1ns/1ps
`include "omc_params.svh"
module operating_mode_control_tb;
   logic clk_sys = 0, rst_b = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic mode_pin_a = 0, mode_pin_b = 0, crystal_input = 0, e_clock = 0, e1;
   logic cpu_rd = 0, cpu_wr = 0, cpu_vec = 0, cpu_int_hit = 0, cpu_first_fetch = 0;
   logic ram_wr_pls = 0, char_tick = 0, brom_sel, rom_off, vec_ext, boot_done, ext_bus_en;
   logic portc_oe_b, rw_out, expansion_address_en, eclk_out, aux_clock_output, aux_q;
   logic first_instruction_strobe, first_instruction_strobe_oe_b;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2, xc = 0;
   logic [15:0] cpu_addr = 16'h12AB, ram_wr_addr = 0, boot_jump, last_addr;
   logic [5:0] cpu_xaddr = 6'h2D, expansion_address;
   logic [7:0] cpu_wdata = 8'h5C, cpu_int_rdata = 8'hA5, portb_out, portf_out, portc_out, last_data;
   int n_mismatch = 0, n_checks = 0, hi_cnt = 0, tog = 0, m, b, c;
   logic [1:0] pins [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
   logic [7:0] mrst [4] = '{8'h06, 8'h26, 8'hC6, 8'h66};
   int dv [4] = '{1, 4, 6, 8};
   assign hready = hreadyout;

   omc_top i_dut (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hrdata, .hresp, .mode_pin_a, .mode_pin_b, .crystal_input, .e_clock,
      .cpu_addr, .cpu_xaddr, .cpu_rd, .cpu_wr, .cpu_vec, .cpu_int_hit, .cpu_wdata,
      .cpu_int_rdata, .cpu_first_fetch, .ram_wr_pls, .ram_wr_addr, .char_tick,
      .boot_rom_enable(), .special_mode_flag(), .mode_select_a_flag(), .psel(),
      .portc_open_drain(), .spi_low_bit_first(), .spi_rate_bit_two(), .brom_sel, .rom_off,
      .vec_ext, .boot_done, .boot_jump, .ext_bus_en, .portb_out, .portf_out, .portc_out,
      .portc_oe_b, .rw_out, .expansion_address, .expansion_address_en,
      .first_instruction_strobe, .first_instruction_strobe_oe_b, .eclk_out, .aux_clock_output);

   omc_ext_mem i_mem (.clk_sys, .ext_bus_en, .portb_out, .portf_out, .portc_out, .portc_oe_b,
      .rw_out, .last_addr, .last_data);

   always #4 clk_sys = ~clk_sys;

   // Crystal at an eighth of the system clock, E at half; counters for edge probes
   always @(posedge clk_sys) begin
      xc <= xc + 3'h1;
      if (xc[1:0] == 2'h3) begin
         crystal_input <= ~crystal_input;
      end
      e_clock <= ~e_clock;
      aux_q <= aux_clock_output;
      if (aux_clock_output !== aux_q) begin
         tog <= tog + 1;
      end
      if (first_instruction_strobe === 1'b1 && first_instruction_strobe_oe_b === 1'b0) begin
         hi_cnt <= hi_cnt + 1;
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Single transfer; both phases wait for hready under one bound
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 50) begin
         n_mismatch++;
         tally_and_finish;
      end
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   task automatic eck(input logic [31:0] e);
      @(posedge clk_sys);
      e1 = eclk_out;
      @(posedge clk_sys);
      chk("e clock seen high", e, {31'h0000_0000, e1 | eclk_out});
   endtask

   task automatic strobe(input int e);
      b = hi_cnt;
      @(posedge clk_sys);
      cpu_first_fetch <= 1'b1;
      @(posedge clk_sys);
      cpu_first_fetch <= 1'b0;
      repeat (12) @(posedge clk_sys);
      chk("strobe driven high cycles", e, hi_cnt - b);
   endtask

   task automatic ramw(input logic [15:0] a);
      @(posedge clk_sys);
      ram_wr_pls <= 1'b1;
      ram_wr_addr <= a;
      @(posedge clk_sys);
      ram_wr_pls <= 1'b0;
   endtask

   initial begin
      for (m = 0; m < 4; m++) begin
         rst_b <= 1'b0;
         {mode_pin_b, mode_pin_a} <= pins[m];
         repeat (20) @(posedge clk_sys);
         rst_b <= 1'b1;
         repeat (2) @(posedge clk_sys);
         rdc("mode reg", `OMC_OFS_MPRI, {24'h00_0000, mrst[m]});
         rdc("options reg", `OMC_OFS_OPTS, (m == 3) ? 32'h0000_0010 : 32'h0000_0000);
         rdc("unmapped", 8'h40, 32'h0000_0000);
         case (m)
            0: begin
               chk("bus pins", 0, {ext_bus_en, portb_out, expansion_address_en});
               eck(1);
               ahb(1'b1, `OMC_OFS_OPTS, 32'h0000_00FF);
               rdc("options reg", `OMC_OFS_OPTS, 32'h0000_00DF);
               eck(0);
               strobe(0);
               ahb(1'b1, `OMC_OFS_OPTS, 32'h0000_0000);
               rdc("options reg", `OMC_OFS_OPTS, 32'h0000_0010);
               ahb(1'b1, `OMC_OFS_MPRI, 32'h0000_0026);
               rdc("mode reg", `OMC_OFS_MPRI, 32'h0000_0026);
               ahb(1'b1, `OMC_OFS_MPRI, 32'h0000_00C7);
               rdc("mode reg", `OMC_OFS_MPRI, 32'h0000_0027);
            end
            1: begin
               ahb(1'b1, `OMC_OFS_OPTS, 32'h0000_0080);
               strobe(`OMC_STRB_HI_CYC);
               cpu_wr <= 1'b1;
               repeat (3) @(posedge clk_sys);
               cpu_wr <= 1'b0;
               chk("bus write", 32'h0012_AB5C, {last_addr, last_data});
               chk("port g", 32'h0000_006D, {expansion_address_en, expansion_address});
            end
            2: begin
               cpu_rd <= 1'b1;
               cpu_addr <= 16'hBE00;
               repeat (3) @(posedge clk_sys);
               chk("boot rom low edge", 1, brom_sel);
               cpu_addr <= 16'hBDFF;
               repeat (3) @(posedge clk_sys);
               chk("below boot rom", 0, brom_sel);
               cpu_addr <= 16'hBE00;
               ramw(16'h0100);
               repeat (2) @(posedge clk_sys);
               chk("download early", 0, {boot_done, boot_jump});
               ramw(16'h037F);
               repeat (3) @(posedge clk_sys);
               chk("download end", 32'h0001_0080, {boot_done, boot_jump});
               ahb(1'b1, `OMC_OFS_OPTS, 32'h0000_0010);
               ahb(1'b1, `OMC_OFS_OPTS, 32'h0000_0000);
               rdc("options reg", `OMC_OFS_OPTS, 32'h0000_0000);
               ahb(1'b1, `OMC_OFS_MPRI, 32'h0000_0006);
               rdc("mode reg", `OMC_OFS_MPRI, 32'h0000_0006);
               chk("boot rom off", 0, brom_sel);
               ahb(1'b1, `OMC_OFS_MPRI, 32'h0000_0046);
               rdc("mode reg", `OMC_OFS_MPRI, 32'h0000_0006);
               cpu_rd <= 1'b0;
               cpu_addr <= 16'h12AB;
            end
            default: begin
               {cpu_vec, cpu_rd, cpu_int_hit} <= 3'h7;
               cpu_addr <= 16'hBFC0;
               repeat (3) @(posedge clk_sys);
               chk("test map", 3'b110, {rom_off, vec_ext, expansion_address_en});
               chk("read visibility", 8'hA5, portc_out);
               {cpu_vec, cpu_rd} <= 2'b00;
               ahb(1'b1, `OMC_OFS_MPRI, 32'h0000_0046);
               rdc("mode reg", `OMC_OFS_MPRI, 32'h0000_0046);
               ahb(1'b1, `OMC_OFS_MPRI, 32'h0000_0066);
               rdc("mode reg", `OMC_OFS_MPRI, 32'h0000_0066);
               for (c = 0; c < 4; c++) begin
                  ahb(1'b1, `OMC_OFS_OPTS, 32'h0000_0010 | c);
                  repeat (200) @(posedge clk_sys);
                  b = tog;
                  repeat (384) @(posedge clk_sys);
                  chk("aux toggles", 96 / dv[c], tog - b);
               end
            end
         endcase
         $display("mode test %0d done", m);
      end
      tally_and_finish;
   end
endmodule // operating_mode_control_tb
